// >>> battery_charger_control_status_regs.sv
/*
  Charger control and status register bank with the charger phase sequencer.
  Holds charge level and protection settings, clear-on-read event flags with masks,
  and the phase status with timer expiry bits. Assumes a byte register port driven
  by the host serial slave on the same clock, asynchronous analog sense pins, and
  the enable override and fast time limit fields supplied from the first control
  register elsewhere in the device.

*/
`timescale 1ns/1ps
module battery_charger_control_status_regs
  import charger_regs_pkg::*;
#(
  parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Fields held in the first control register
  input wire logic charger_enable_override,
  input wire logic [1:0] fast_time_limit,
  // Analog side
  input wire sense_type sense_pins,
  output drive_type drive,
  // Host interrupt
  output logic charger_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sense_type sense;
  logic sec_tick;
  logic [7:0] level_reg;
  logic [7:0] protect_reg;
  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  logic [5:0] mask_reg;
  logic [1:0] expired_reg;
  logic [1:0] expired_next;
  phase_type state_reg;
  phase_type state_next;
  logic [ELAPSED_WIDTH-1:0] elapsed_reg;
  logic attached_prev_reg;
  logic override_prev_reg;
  logic [7:0] rdata_next;
  drive_type drive_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Phase to flag/status bit pattern; halted counts as not charging
  function automatic logic [5:0] phase_bits(input phase_type ph);
    logic [5:0] bits;
    bits = 6'h00;
    unique case (ph)
      PH_IDLE, PH_HALTED: bits[IDLE_PHASE_BIT] = 1'b1;
      PH_PRE: bits[PRE_PHASE_BIT] = 1'b1;
      PH_FAST: bits[FAST_PHASE_BIT] = 1'b1;
      PH_CV: bits[CV_PHASE_BIT] = 1'b1;
      PH_DONE: bits[COMPLETE_BIT] = 1'b1;
      PH_FAULT: bits[FAULT_BIT] = 1'b1;
    endcase
    return bits;
  endfunction

  function automatic logic [ELAPSED_WIDTH-1:0] fast_limit_sec(input logic [1:0] code);
    return ELAPSED_WIDTH'((FAST_LIMIT_BASE_HOURS + int'(code)) * SEC_PER_HOUR);
  endfunction

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ****************************************************************
  // Pin conditioning and time base
  // ****************************************************************
  pin_sync #(.WIDTH($bits(sense_type))) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(sense_pins),
    .level_out(sense)
  );

  second_tick #(.CYCLES(SEC_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(sec_tick)
  );

  // ****************************************************************
  // Decode of register port and fields
  // ****************************************************************
  wire wr_level = reg_wr && is_addr(reg_addr, CHARGE_LEVEL_OFFSET);
  wire wr_protect = reg_wr && is_addr(reg_addr, PROTECTION_OFFSET);
  wire wr_mask = reg_wr && is_addr(reg_addr, EVENT_MASK_OFFSET);
  wire wr_status = reg_wr && is_addr(reg_addr, PHASE_STATE_OFFSET);
  wire rd_flags = reg_rd && is_addr(reg_addr, EVENT_FLAGS_OFFSET);
  wire [3:0] done_code = level_reg[DONE_LEVEL_LSB +: 4];
  wire [3:0] cv_code = level_reg[CV_TARGET_LSB +: 4];
  wire [1:0] ov_code = protect_reg[OV_THRESH_LSB +: 2];
  wire auto_shutoff_enable = protect_reg[AUTO_SHUTOFF_BIT];
  wire current_range_select = protect_reg[RANGE_SELECT_BIT];
  wire [3:0] fast_current_setting = protect_reg[FAST_SETTING_LSB +: 4];

  // ****************************************************************
  // Enable, resume and timer conditions
  // ****************************************************************
  wire charger_enabled = charger_enable_override | sense.attached;
  wire attach_rise = sense.attached && !attached_prev_reg;
  wire override_toggle = charger_enable_override != override_prev_reg;
  wire resume_event = attach_rise | override_toggle;
  wire pre_expired = elapsed_reg >= ELAPSED_WIDTH'(PRECHARGE_LIMIT_SEC);
  wire fast_expired = (fast_time_limit != FAST_LIMIT_OFF) &&
                      (elapsed_reg >= fast_limit_sec(fast_time_limit));
  wire stop_expired = elapsed_reg >= ELAPSED_WIDTH'(AUTO_STOP_LIMIT_SEC);
  wire phase_change = state_next != state_reg;
  wire [5:0] entry_bits = phase_change ? phase_bits(state_next) : 6'h00;
  wire [5:0] status_bits = phase_bits(state_reg);
  wire pre_halt_set = (state_reg == PH_PRE) && (state_next == PH_HALTED);
  wire fast_halt_set = (state_reg == PH_FAST) && (state_next == PH_HALTED);

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  // A halted charger ignores enable and fault until an explicit resume
  always_comb begin
    state_next = state_reg;
    if (state_reg == PH_HALTED) begin
      if (resume_event) begin
        state_next = PH_IDLE;
      end
    end else if (!charger_enabled) begin
      state_next = PH_IDLE;
    end else if (sense.fault) begin
      state_next = PH_FAULT;
    end else begin
      unique case (state_reg)
        PH_IDLE: state_next = PH_PRE;
        PH_PRE: begin
          if (pre_expired) begin
            state_next = PH_HALTED;
          end else if (sense.above_precharge) begin
            state_next = PH_FAST;
          end
        end
        PH_FAST: begin
          if (fast_expired) begin
            state_next = PH_HALTED;
          end else if (sense.cv_reached) begin
            state_next = PH_CV;
          end
        end
        PH_CV: begin
          if (auto_shutoff_enable && stop_expired) begin
            state_next = PH_DONE;
          end
        end
        PH_DONE: state_next = PH_DONE;
        PH_FAULT: state_next = PH_IDLE;
        PH_HALTED: state_next = PH_HALTED;
      endcase
    end
  end

  // Phase timer restarts on every phase change, counts whole seconds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= PH_IDLE;
      elapsed_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (phase_change) begin
        elapsed_reg <= '0;
      end else if (sec_tick && !(&elapsed_reg)) begin
        elapsed_reg <= elapsed_reg + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Flags, mask and expiry bits
  // ****************************************************************
  // Hardware set wins over a read clear in the same cycle
  assign flags_next = (flags_reg & ~(rd_flags ? 6'h3f : 6'h00)) | entry_bits;
  // Writing 0 clears an expiry bit; a new expiry in that cycle still lands
  assign expired_next = (expired_reg & (wr_status ?
                         reg_wdata[PRE_EXPIRED_BIT +: 2] : 2'b11)) | {fast_halt_set, pre_halt_set};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg <= CHARGE_LEVEL_RESET;
      protect_reg <= PROTECTION_RESET;
      flags_reg <= EVENT_FLAGS_RESET;
      mask_reg <= EVENT_MASK_RESET;
      expired_reg <= 2'b00;
      attached_prev_reg <= 1'b0;
      override_prev_reg <= 1'b0;
    end else begin
      if (wr_level) begin
        level_reg <= reg_wdata;
      end
      if (wr_protect) begin
        protect_reg <= reg_wdata;
      end
      if (wr_mask) begin
        mask_reg <= reg_wdata[5:0];
      end
      flags_reg <= flags_next;
      expired_reg <= expired_next;
      attached_prev_reg <= sense.attached;
      override_prev_reg <= charger_enable_override;
    end
  end

  assign charger_irq = |(flags_reg & ~mask_reg);

  // ****************************************************************
  // Read data and analog settings
  // ****************************************************************
  // Unmapped offsets read as zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      CHARGE_LEVEL_OFFSET: rdata_next = level_reg;
      PROTECTION_OFFSET: rdata_next = protect_reg;
      EVENT_FLAGS_OFFSET: rdata_next = {2'b00, flags_reg};
      EVENT_MASK_OFFSET: rdata_next = {2'b00, mask_reg};
      PHASE_STATE_OFFSET: rdata_next = {expired_reg, status_bits};
      default: rdata_next = 8'h00;
    endcase
  end

  always_comb begin
    drive_next.charge_on = (state_reg == PH_PRE) || (state_reg == PH_FAST) ||
                           (state_reg == PH_CV);
    drive_next.cv_mode = state_reg == PH_CV;
    drive_next.fast_ma = current_range_select ?
      10'(FAST_BASE_MA + FAST_STEP_MA * int'(fast_current_setting)) :
      10'(LOW_RANGE_MA);
    drive_next.done_ma = 8'(DONE_BASE_MA + DONE_STEP_MA * int'(done_code));
    drive_next.cv_mv = (cv_code == CV_TOP_CODE) ? 13'(CV_TOP_MV) :
      13'(CV_BASE_MV + CV_STEP_MV * int'(cv_code));
    drive_next.ov_limit_mv = 13'(OV_BASE_MV + OV_STEP_MV * int'(ov_code));
  end

  // Reads return data on the edge after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      drive <= '0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
      drive <= drive_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence fast_to_halt_s;
    (state_reg == PH_FAST) && (state_next == PH_HALTED);
  endsequence

  sequence pre_to_halt_s;
    (state_reg == PH_PRE) && (state_next == PH_HALTED);
  endsequence

  level_reset_value_a: assert property ($fell(rst) |-> level_reg == 8'h1a)
    else $error("charge level register left reset with wrong value");
  cv_transition_a: assert property (
    (state_reg == PH_FAST) && charger_enabled && !sense.fault && !fast_expired &&
    sense.cv_reached |=> state_reg == PH_CV)
    else $error("fast charge did not move to constant voltage");
  ov_scale_a: assert property (ov_code == 2'b11 |=> drive.ov_limit_mv == 13'd7500)
    else $error("overvoltage threshold scale wrong");
  no_auto_stop_a: assert property (
    (state_reg == PH_CV) && !auto_shutoff_enable |=> state_reg != PH_DONE)
    else $error("charger left constant voltage with auto shutoff off");
  low_range_a: assert property (!current_range_select |=> drive.fast_ma == 10'd90)
    else $error("low range did not limit fast current");
  fast_code_a: assert property (
    current_range_select && fast_current_setting == 4'hf |=> drive.fast_ma == 10'd950)
    else $error("fast current scale wrong");
  read_clears_a: assert property (
    rd_flags && !phase_change |=> flags_reg == 6'h00 ##1 flags_reg == $past(entry_bits))
    else $error("flag read did not clear flags");
  entry_flag_a: assert property (
    phase_change && state_next == PH_FAST |=> flags_reg[FAST_PHASE_BIT])
    else $error("entering fast charge did not set its flag");
  unused_zero_a: assert property (
    reg_rd && (reg_addr == EVENT_FLAGS_OFFSET || reg_addr == EVENT_MASK_OFFSET)
    |=> reg_rdata[7:6] == 2'b00)
    else $error("unused flag or mask bits read nonzero");
  mask_gate_a: assert property (mask_reg == 6'h3f |-> !charger_irq)
    else $error("fully masked flags raised the interrupt");
  phase_read_a: assert property (
    reg_rd && reg_addr == PHASE_STATE_OFFSET && state_reg == PH_CV
    |=> reg_rdata[CV_PHASE_BIT] && !reg_rdata[FAST_PHASE_BIT])
    else $error("status phase bits wrong");
  fault_read_a: assert property (
    reg_rd && reg_addr == PHASE_STATE_OFFSET && state_reg == PH_FAULT
    |=> reg_rdata[FAULT_BIT])
    else $error("status fault bit missing");
  fast_expiry_a: assert property (
    fast_to_halt_s |=> expired_reg[1] ##1 !drive.charge_on)
    else $error("fast timer expiry not flagged or charging not stopped");
  pre_expiry_a: assert property (
    pre_to_halt_s |=> expired_reg[0] ##1 !drive.charge_on)
    else $error("pre-charge expiry not flagged or charging not stopped");
  halt_hold_a: assert property (
    state_reg == PH_HALTED && !resume_event |=> state_reg == PH_HALTED)
    else $error("charger resumed without attach or override toggle");
  override_on_a: assert property (
    charger_enable_override && state_reg == PH_IDLE && !sense.fault &&
    !override_toggle |=> state_reg == PH_PRE)
    else $error("override did not enable charging");
  irq_unmasked_a: assert property (
    |(entry_bits & ~mask_reg) && !wr_mask |=> charger_irq)
    else $error("unmasked flag did not raise interrupt");

endmodule

// >>> charger_regs_pkg.sv
/*
  Shared constants and types for the charger control and status register bank:
  register offsets, field positions, reset values, timing counts, the charger
  phase enumeration and the packed carriers for sense pins and analog settings.
  Assumes a 40 MHz system clock and a register port behind the host serial slave.
*/
package charger_regs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] CHARGE_LEVEL_OFFSET = 8'h21;
  localparam logic [7:0] PROTECTION_OFFSET = 8'h22;
  localparam logic [7:0] EVENT_FLAGS_OFFSET = 8'h24;
  localparam logic [7:0] EVENT_MASK_OFFSET = 8'h25;
  localparam logic [7:0] PHASE_STATE_OFFSET = 8'h26;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DONE_LEVEL_LSB = 4;
  localparam int CV_TARGET_LSB = 0;
  localparam int OV_THRESH_LSB = 6;
  localparam int AUTO_SHUTOFF_BIT = 5;
  localparam int RANGE_SELECT_BIT = 4;
  localparam int FAST_SETTING_LSB = 0;
  localparam int FAULT_BIT = 5;
  localparam int COMPLETE_BIT = 4;
  localparam int CV_PHASE_BIT = 3;
  localparam int FAST_PHASE_BIT = 2;
  localparam int PRE_PHASE_BIT = 1;
  localparam int IDLE_PHASE_BIT = 0;
  localparam int FAST_EXPIRED_BIT = 7;
  localparam int PRE_EXPIRED_BIT = 6;
  localparam int EVENT_COUNT = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CHARGE_LEVEL_RESET = 8'h1a;
  localparam logic [7:0] PROTECTION_RESET = 8'hd5;
  localparam logic [5:0] EVENT_FLAGS_RESET = 6'h00;
  localparam logic [5:0] EVENT_MASK_RESET = 6'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_SEC = 1000000000;
  localparam int CYCLES_PER_SEC = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_HOUR = 3600;
  localparam int PRECHARGE_LIMIT_MIN = 30;
  localparam int AUTO_STOP_LIMIT_MIN = 30;
  localparam int PRECHARGE_LIMIT_SEC = PRECHARGE_LIMIT_MIN * SEC_PER_MIN;
  localparam int AUTO_STOP_LIMIT_SEC = AUTO_STOP_LIMIT_MIN * SEC_PER_MIN;
  localparam int FAST_LIMIT_BASE_HOURS = 5;
  localparam logic [1:0] FAST_LIMIT_OFF = 2'b11;
  localparam int ELAPSED_WIDTH = 15;

  // ****************************************************************
  // Analog setting scales
  // ****************************************************************
  localparam int DONE_BASE_MA = 50;
  localparam int DONE_STEP_MA = 10;
  localparam int CV_BASE_MV = 4000;
  localparam int CV_STEP_MV = 20;
  localparam int CV_TOP_MV = 4350;
  localparam logic [3:0] CV_TOP_CODE = 4'hf;
  localparam int OV_BASE_MV = 6000;
  localparam int OV_STEP_MV = 500;
  localparam int FAST_BASE_MA = 200;
  localparam int FAST_STEP_MA = 50;
  localparam int LOW_RANGE_MA = 90;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_IDLE, PH_PRE, PH_FAST, PH_CV, PH_DONE, PH_FAULT, PH_HALTED
  } phase_type;

  typedef struct packed {
    logic attached;
    logic above_precharge;
    logic cv_reached;
    logic fault;
  } sense_type;

  typedef struct packed {
    logic charge_on;
    logic cv_mode;
    logic [9:0] fast_ma;
    logic [7:0] done_ma;
    logic [12:0] cv_mv;
    logic [12:0] ov_limit_mv;
  } drive_type;

endpackage

// >>> pin_sync.sv
/*
  Three-stage synchroniser for a group of asynchronous pins.
  Assumes the pins are slow levels; a change is taken once stages two and three agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  if (WIDTH < 1) begin : g_width_chk
    $error("pin_sync width must be at least one");
  end

  // ****************************************************************
  // One chain per pin
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic first_reg;
    logic second_reg;
    logic third_reg;
    // First stage feeds only the second, to keep metastability contained
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        first_reg <= 1'b0;
        second_reg <= 1'b0;
        third_reg <= 1'b0;
        level_out[i] <= 1'b0;
      end else begin
        first_reg <= pin_in[i];
        second_reg <= first_reg;
        third_reg <= second_reg;
        if (second_reg == third_reg) begin
          level_out[i] <= third_reg;
        end
      end
    end
  end

endmodule

// >>> second_tick.sv
/*
  Free-running prescaler giving a one-cycle pulse once per second.
  Assumes the system clock; the period is a parameter so simulation can shorten it.
*/
`timescale 1ns/1ps
module second_tick #(
  parameter int CYCLES = 40000000
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Pulse out
  output logic tick
);

  if (CYCLES < 2) begin : g_cycles_chk
    $error("second_tick needs at least two cycles per tick");
  end

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic wrap;

  // ****************************************************************
  // Divider
  // ****************************************************************
  assign wrap = (count_reg == 32'(CYCLES - 1));
  assign count_next = wrap ? 32'h0000_0000 : count_reg + 32'h0000_0001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= wrap;
    end
  end

endmodule

// >>> battery_model.sv
/*
  Battery and adapter model that drives the charger sense pins.
  Assumes the bench steers attach, fault and the stall controls on the same clock.
*/
`timescale 1ns/1ps
module battery_model
  import charger_regs_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Charger output and bench controls
  input wire drive_type drive,
  input wire logic attach,
  input wire logic fault,
  input wire logic stall_pre,
  input wire logic stall_cv,
  // Sense pins
  output sense_type sense
);
  logic [7:0] level_reg;
  // Cell rises only while current flows; a detach empties it
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      level_reg <= 8'h00;
    else if (!attach)
      level_reg <= 8'h00;
    else if (drive.charge_on && level_reg != 8'hff)
      level_reg <= level_reg + 8'h01;
  end
  // Low thresholds so each phase passes in a few cycles
  assign sense = {attach, (level_reg >= 8'h08) && !stall_pre, (level_reg >= 8'h10) && !stall_cv,
                  fault};
endmodule

// >>> battery_charger_control_status_regs_test.sv
/*
  Self-checking bench for the charger register bank and phase sequencer.
  Assumes the battery model on the sense pins and a one-second tick of 2 cycles.
*/
`timescale 1ns/1ps
module battery_charger_control_status_regs_test;
  import charger_regs_pkg::*;
  logic clk, rst, reg_wr, reg_rd, charger_enable_override, charger_irq;
  logic attach, fault, stall_pre, stall_cv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] fast_time_limit;
  sense_type sense_pins;
  drive_type drive;
  int num_errors = 0;
  int checks_done = 0;

  battery_charger_control_status_regs #(.SEC_CYCLES(2)) i_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .charger_enable_override(charger_enable_override),
    .fast_time_limit(fast_time_limit), .sense_pins(sense_pins), .drive(drive),
    .charger_irq(charger_irq));
  battery_model i_cell (.clk(clk), .rst(rst), .drive(drive), .attach(attach), .fault(fault),
    .stall_pre(stall_pre), .stall_cv(stall_cv), .sense(sense_pins));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(16'(reg_rdata), 16'(exp), what);
  endtask
  // Polls status without counting; a missed bound ends the run
  task automatic wait_stat(input logic [7:0] exp, input int bound);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      reg_addr = PHASE_STATE_OFFSET;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      n++;
    end while (reg_rdata !== exp && n < bound);
    check(16'(reg_rdata), 16'(exp), "phase status");
    if (reg_rdata !== exp)
      summarize();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(CHARGE_LEVEL_OFFSET, 8'h1a, "level reset");
    rd(PROTECTION_OFFSET, 8'hd5, "protection reset");
    rd(EVENT_MASK_OFFSET, 8'h00, "mask reset");
    rd(8'h30, 8'h00, "unmapped");
    wr(EVENT_MASK_OFFSET, 8'hff);
    rd(EVENT_MASK_OFFSET, 8'h3f, "mask top bits");
    wr(EVENT_FLAGS_OFFSET, 8'hff);
    rd(EVENT_FLAGS_OFFSET, 8'h00, "flags not writable");
    wr(EVENT_MASK_OFFSET, 8'h00);
    wr(PHASE_STATE_OFFSET, 8'h3e);
    rd(PHASE_STATE_OFFSET, 8'h01, "idle status");
    wr(PROTECTION_OFFSET, 8'h0f);
    wr(CHARGE_LEVEL_OFFSET, 8'hf0);
    // Drive outputs lag the register by one edge
    @(negedge clk);
    check(16'(drive.fast_ma), 16'(LOW_RANGE_MA), "low range");
    check(16'(drive.ov_limit_mv), 16'(OV_BASE_MV), "threshold 00");
    check(16'(drive.done_ma), 16'(DONE_BASE_MA + 15 * DONE_STEP_MA), "done top");
    check(16'(drive.cv_mv), 16'(CV_BASE_MV), "cv bottom");
    wr(PROTECTION_OFFSET, 8'h9f);
    wr(CHARGE_LEVEL_OFFSET, 8'h2f);
    @(negedge clk);
    check(16'(drive.fast_ma), 16'(FAST_BASE_MA + 15 * FAST_STEP_MA), "fast top");
    check(16'(drive.ov_limit_mv), 16'(OV_BASE_MV + 2 * OV_STEP_MV), "threshold 10");
    check(16'(drive.done_ma), 16'(DONE_BASE_MA + 2 * DONE_STEP_MA), "done 2");
    check(16'(drive.cv_mv), 16'(CV_TOP_MV), "cv top");
    wr(PROTECTION_OFFSET, 8'hd5);
    wr(CHARGE_LEVEL_OFFSET, 8'h1a);
  endtask
  task automatic t_phases();
    attach = 1'b1;
    wait_stat(8'h08, 200);
    check(16'(drive.cv_mode), 16'h0001, "cv mode");
    check(16'(charger_irq), 16'h0001, "irq pending");
    wr(EVENT_MASK_OFFSET, 8'h0e);
    check(16'(charger_irq), 16'h0000, "irq masked");
    wr(EVENT_MASK_OFFSET, 8'h00);
    rd(EVENT_FLAGS_OFFSET, 8'h0e, "entry flags");
    check(16'(charger_irq), 16'h0000, "irq after read");
    rd(EVENT_FLAGS_OFFSET, 8'h00, "flags cleared");
  endtask
  task automatic t_stop_fault();
    wr(PROTECTION_OFFSET, 8'hf5);
    wait_stat(8'h10, 2500);
    check(16'(drive.charge_on), 16'h0000, "stopped");
    fault = 1'b1;
    wait_stat(8'h20, 50);
    rd(EVENT_FLAGS_OFFSET, 8'h30, "done and fault flags");
    fault = 1'b0;
    // Idle lasts one cycle; a full cell then runs straight through to voltage
    wait_stat(8'h08, 50);
  endtask
  task automatic t_expiry();
    attach = 1'b0;
    stall_pre = 1'b1;
    wr(PROTECTION_OFFSET, 8'hd5);
    attach = 1'b1;
    wait_stat(8'h41, 2500);
    repeat (40) @(negedge clk);
    check(16'(drive.charge_on), 16'h0000, "halted");
    rd(PHASE_STATE_OFFSET, 8'h41, "stays halted");
    charger_enable_override = 1'b1;
    wait_stat(8'h42, 50);
    wr(PHASE_STATE_OFFSET, 8'h00);
    rd(PHASE_STATE_OFFSET, 8'h02, "expiry cleared");
    // Timer off first, so fast charge must outlive the five hour limit
    fast_time_limit = 2'b11;
    stall_pre = 1'b0;
    stall_cv = 1'b1;
    wait_stat(8'h04, 50);
    repeat (37000) @(negedge clk);
    rd(PHASE_STATE_OFFSET, 8'h04, "fast timer off");
    fast_time_limit = 2'b00;
    wait_stat(8'h81, 20);
  endtask

  // Clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, charger_enable_override, attach, fault, stall_pre, stall_cv} = 8'h80;
    {reg_addr, reg_wdata, fast_time_limit} = 18'h0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_phases();
    t_stop_fault();
    t_expiry();
    summarize();
  end
endmodule
